/* csr_pkg.sv */
// shared constants and types for the core status and option registers
package csr_pkg;
  // status register location and field positions
  localparam logic [7:0] CSR_STATUS_ADDR   = 8'h03;
  localparam int         CSR_BIT_C         = 0;
  localparam int         CSR_BIT_DC        = 1;
  localparam int         CSR_BIT_Z         = 2;
  localparam int         CSR_BIT_PD        = 3;
  localparam int         CSR_BIT_TO        = 4;
  localparam int         CSR_PAGE_LSB      = 5;
  localparam int         CSR_PAGE_W        = 3;
  // reset values
  localparam logic [2:0] CSR_PAGE_RST      = 3'h0;
  localparam logic       CSR_TO_RST        = 1'b1;
  localparam logic       CSR_PD_RST        = 1'b1;
  localparam logic [2:0] CSR_FLAGS_RST     = 3'h0;
  // option register layout
  localparam int         CSR_OPT_W         = 6;
  localparam logic [5:0] CSR_OPT_RST       = 6'h3f;
  localparam int         CSR_OPT_CS        = 5;
  localparam int         CSR_OPT_SE        = 4;
  localparam int         CSR_OPT_PSA       = 3;
  localparam int         CSR_OPT_RATE_LSB  = 0;
  localparam int         CSR_RATE_W        = 3;
  localparam int         CSR_TDIV_W        = 4;
  localparam logic [3:0] CSR_TDIV_RST      = 4'h8;
  localparam logic [3:0] CSR_TDIV_OFS      = 4'h1;
  // low nibble overflow threshold for digit carry
  localparam logic [4:0] CSR_NIB_CARRY     = 5'h10;
  // alu operation classes; all but CSR_OP_NONE touch the flags
  typedef enum logic [2:0] {
    CSR_OP_NONE  = 3'h0,
    CSR_OP_ADD   = 3'h1,
    CSR_OP_SUB   = 3'h2,
    CSR_OP_RRF   = 3'h3,
    CSR_OP_RLF   = 3'h4,
    CSR_OP_LOGIC = 3'h5
  } csr_op_t;
endpackage

/* csr_option_reg.sv */
// write-only timer/prescaler option register storage
`timescale 1ns/10ps
`default_nettype none
module csr_option_reg
  import csr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  ce,
  input  wire logic                  load,
  input  wire logic [CSR_OPT_W-1:0]  wdata,
  output logic      [CSR_OPT_W-1:0]  opt_q,
  output logic      [CSR_TDIV_W-1:0] tdiv_q
);
  logic [CSR_OPT_W-1:0]  opt_ff;
  logic [CSR_OPT_W-1:0]  nxt_opt;
  logic [CSR_TDIV_W-1:0] tdiv_ff;
  logic [CSR_TDIV_W-1:0] nxt_tdiv;

  // next option value; timer exponent kept pre-added so the output is a flop
  always_comb begin
    nxt_opt  = opt_ff;
    nxt_tdiv = tdiv_ff;
    if (load) begin
      nxt_opt  = wdata;
      nxt_tdiv = {1'b0, wdata[CSR_OPT_RATE_LSB +: CSR_RATE_W]} + CSR_TDIV_OFS;
    end
  end

  // reset wins over the clock enable so a frozen core still initialises
  always_ff @(posedge clk) begin
    if (srst) begin
      opt_ff  <= CSR_OPT_RST;
      tdiv_ff <= CSR_TDIV_RST;
    end else if (ce) begin
      opt_ff  <= nxt_opt;
      tdiv_ff <= nxt_tdiv;
    end
  end

  assign opt_q  = opt_ff;
  assign tdiv_q = tdiv_ff;
endmodule
`default_nettype wire

/* csr_regs.sv */
// core status register, option register and timer tick selection
`timescale 1ns/10ps
`default_nettype none
module csr_regs
  import csr_pkg::*;
#(
  parameter bit HAS_WDT_PSC = 1'b1
)(
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        CE,
  input  wire logic        EXEC,
  input  wire logic        OPT_LOAD,
  input  wire logic [7:0]  W_DATA,
  input  wire logic        STAT_WR,
  input  wire logic [7:0]  STAT_WDATA,
  input  wire csr_op_t     ALU_OP,
  input  wire logic [7:0]  ALU_A,
  input  wire logic [7:0]  ALU_B,
  input  wire logic        CLRWDT_EXEC,
  input  wire logic        SLEEP_EXEC,
  input  wire logic        WDT_TIMEOUT,
  input  wire logic        TIMER_EXT_CLOCK_PIN,
  output logic [7:0]       STATUS_RD,
  output logic [7:0]       ALU_RES,
  output logic [1:0]       PC_PAGE,
  output logic             TIMER_CLOCK_SOURCE_SEL,
  output logic             TIMER_EDGE_SEL,
  output logic             PRESCALER_ASSIGN,
  output logic [2:0]       PRESCALER_RATE,
  output logic [3:0]       TMR_DIV_EXP,
  output logic             TMR_INC
);
  logic [CSR_OPT_W-1:0]  opt_q;
  logic [CSR_TDIV_W-1:0] tdiv_q;
  logic [2:0] page_ff;
  logic [2:0] nxt_page;
  logic       to_ff;
  logic       nxt_to;
  logic       pd_ff;
  logic       nxt_pd;
  logic       z_ff;
  logic       nxt_z;
  logic       dc_ff;
  logic       nxt_dc;
  logic       c_ff;
  logic       nxt_c;
  logic [7:0] res_ff;
  logic [7:0] nxt_res;
  logic       pin_prev_ff;
  logic       inc_ff;
  logic       nxt_inc;

  // only the low six bits of the working register reach storage
  csr_option_reg u_opt (
    .clk    (CLK),
    .srst   (SRST),
    .ce     (CE),
    .load   (EXEC & OPT_LOAD),
    .wdata  (W_DATA[CSR_OPT_W-1:0]),
    .opt_q  (opt_q),
    .tdiv_q (tdiv_q)
  );

  // alu flags and status write merge
  always_comb begin
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic       upd;
    sum9    = {1'b0, ALU_A} + {1'b0, ALU_B};
    nib5    = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]};
    upd     = 1'b0;
    nxt_page = page_ff;
    nxt_z    = z_ff;
    nxt_dc   = dc_ff;
    nxt_c    = c_ff;
    nxt_res  = res_ff;
    if (EXEC) begin
      case (ALU_OP)
        CSR_OP_ADD: begin
          nxt_res = sum9[7:0];
          nxt_c   = sum9[8];
          nxt_dc  = (nib5 >= CSR_NIB_CARRY);
          nxt_z   = (sum9[7:0] == 8'h00);
          upd     = 1'b1;
        end
        CSR_OP_SUB: begin
          nxt_res = ALU_A - ALU_B;
          nxt_c   = (ALU_A >= ALU_B);
          nxt_dc  = (ALU_A[3:0] >= ALU_B[3:0]);
          nxt_z   = (ALU_A == ALU_B);
          upd     = 1'b1;
        end
        CSR_OP_RRF: begin
          nxt_res = {c_ff, ALU_A[7:1]};
          nxt_c   = ALU_A[0];
          upd     = 1'b1;
        end
        CSR_OP_RLF: begin
          nxt_res = {ALU_A[6:0], c_ff};
          nxt_c   = ALU_A[7];
          upd     = 1'b1;
        end
        CSR_OP_LOGIC: begin
          nxt_res = ALU_A;
          nxt_z   = (ALU_A == 8'h00);
          upd     = 1'b1;
        end
        default: begin
          nxt_res = ALU_A;
        end
      endcase
      if (STAT_WR) begin
        nxt_page = STAT_WDATA[CSR_PAGE_LSB +: CSR_PAGE_W];
        // flag results beat the destination write
        if (!upd) begin
          nxt_z  = STAT_WDATA[CSR_BIT_Z];
          nxt_dc = STAT_WDATA[CSR_BIT_DC];
          nxt_c  = STAT_WDATA[CSR_BIT_C];
        end
      end
    end
  end

  // time-out and power-down follow device events only, never the write data
  always_comb begin
    nxt_to = to_ff;
    nxt_pd = pd_ff;
    if (CLRWDT_EXEC) begin
      nxt_to = 1'b1;
      nxt_pd = 1'b1;
    end else if (SLEEP_EXEC) begin
      nxt_to = 1'b1;
      nxt_pd = 1'b0;
    end
    // a time-out in the same cycle is not lost
    if (WDT_TIMEOUT) begin
      nxt_to = 1'b0;
    end
  end

  // timer increment source and edge
  always_comb begin
    nxt_inc = 1'b1;
    if (opt_q[CSR_OPT_CS]) begin
      nxt_inc = opt_q[CSR_OPT_SE] ? (pin_prev_ff & ~TIMER_EXT_CLOCK_PIN)
                                  : (~pin_prev_ff & TIMER_EXT_CLOCK_PIN);
    end
  end

  // status and tick state
  always_ff @(posedge CLK) begin
    if (SRST) begin
      page_ff     <= CSR_PAGE_RST;
      to_ff       <= CSR_TO_RST;
      pd_ff       <= CSR_PD_RST;
      {z_ff, dc_ff, c_ff} <= CSR_FLAGS_RST;
      res_ff      <= 8'h00;
      pin_prev_ff <= TIMER_EXT_CLOCK_PIN; // start at the pin level so reset makes no false edge
      inc_ff      <= 1'b0;
    end else if (CE) begin
      page_ff     <= nxt_page;
      to_ff       <= nxt_to;
      pd_ff       <= nxt_pd;
      z_ff        <= nxt_z;
      dc_ff       <= nxt_dc;
      c_ff        <= nxt_c;
      res_ff      <= nxt_res;
      pin_prev_ff <= TIMER_EXT_CLOCK_PIN;
      inc_ff      <= nxt_inc;
    end
  end

  // read view of status; option storage has no read port at all
  assign STATUS_RD = {page_ff, to_ff, pd_ff, z_ff, dc_ff, c_ff};
  assign ALU_RES   = res_ff;
  assign PC_PAGE   = page_ff[1:0];
  assign TIMER_CLOCK_SOURCE_SEL = opt_q[CSR_OPT_CS];
  assign TIMER_EDGE_SEL         = opt_q[CSR_OPT_SE];
  // smallest variant cannot hand the prescaler to the watchdog
  assign PRESCALER_ASSIGN = opt_q[CSR_OPT_PSA] & HAS_WDT_PSC;
  assign PRESCALER_RATE   = opt_q[CSR_OPT_RATE_LSB +: CSR_RATE_W];
  assign TMR_DIV_EXP      = tdiv_q;
  assign TMR_INC          = inc_ff;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_rot_r;
    CE && EXEC && ALU_OP == CSR_OP_RRF && !STAT_WR;
  endsequence

  property p_opt_load;
    CE && EXEC && OPT_LOAD |=> PRESCALER_RATE == $past(W_DATA[2:0]) && TMR_DIV_EXP == {1'b0, $past(W_DATA[2:0])} + 4'h1;
  endproperty
  a_opt_load: assert property (p_opt_load) else $error("option load lost");

  property p_opt_rst;
    disable iff (1'b0) SRST |=> TIMER_CLOCK_SOURCE_SEL && TIMER_EDGE_SEL && PRESCALER_RATE == 3'h7 && TMR_DIV_EXP == 4'h8;
  endproperty
  a_opt_rst: assert property (p_opt_rst) else $error("option reset value wrong");

  property p_int_clk;
    CE && !TIMER_CLOCK_SOURCE_SEL |=> TMR_INC;
  endproperty
  a_int_clk: assert property (p_int_clk) else $error("internal tick missing");

  property p_fall;
    CE && TIMER_CLOCK_SOURCE_SEL && TIMER_EDGE_SEL && !TIMER_EXT_CLOCK_PIN ##1
      CE && TIMER_CLOCK_SOURCE_SEL && TIMER_EDGE_SEL && !TIMER_EXT_CLOCK_PIN |=> !TMR_INC;
  endproperty
  a_fall: assert property (p_fall) else $error("tick without falling edge");

  property p_rrf;
    s_rot_r |=> STATUS_RD[0] == $past(ALU_A[0]) && ALU_RES[6:0] == $past(ALU_A[7:1]);
  endproperty
  a_rrf: assert property (p_rrf) else $error("rotate carry wrong");

  property p_page_rst;
    disable iff (1'b0) SRST |=> PC_PAGE == 2'h0 && STATUS_RD[7:5] == 3'h0;
  endproperty
  a_page_rst: assert property (p_page_rst) else $error("page not cleared");

  logic [8:0] sum_chk;
  assign sum_chk = {1'b0, ALU_A} + {1'b0, ALU_B};

  property p_block;
    CE && EXEC && STAT_WR && ALU_OP == CSR_OP_ADD |=> STATUS_RD[0] == $past(sum_chk[8]);
  endproperty
  a_block: assert property (p_block) else $error("status write reached carry");

  property p_to_pd;
    !CLRWDT_EXEC && !SLEEP_EXEC && !WDT_TIMEOUT |=> $stable(STATUS_RD[4:3]);
  endproperty
  a_to_pd: assert property (p_to_pd) else $error("time-out or power-down changed");

  property p_zero;
    CE && EXEC && ALU_OP == CSR_OP_LOGIC && !STAT_WR |=> STATUS_RD[2] == (ALU_RES == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_sub;
    CE && EXEC && ALU_OP == CSR_OP_SUB |=> STATUS_RD[0] == ($past(ALU_A) >= $past(ALU_B));
  endproperty
  a_sub: assert property (p_sub) else $error("borrow flag wrong");
endmodule
`default_nettype wire

/* csr_regs_tb.sv */
// self-checking bench for the core status and option registers
`timescale 1ns/10ps
`default_nettype none
module testbench
  import csr_pkg::*;
;
  logic       clk = 1'b0, srst = 1'b1, ce = 1'b1, exec = 1'b0, opt_load = 1'b0, stat_wr = 1'b0;
  logic       clrwdt = 1'b0, sleep = 1'b0, wdt_to = 1'b0, pin = 1'b0, hit;
  logic [7:0] w_data = 8'h00, stat_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
  csr_op_t    alu_op = CSR_OP_NONE;
  logic [7:0] status_rd, alu_res;
  logic [1:0] pc_page;
  logic       cs, se, prescaler_assign, tmr_inc;
  logic [2:0] rate;
  logic [3:0] tdiv;
  int         error_cnt = 0, n_compared = 0;

  // 40 MHz instruction clock
  always #12.5 clk = ~clk;

  csr_regs u_csr_regs (.CLK(clk), .SRST(srst), .CE(ce), .EXEC(exec), .OPT_LOAD(opt_load), .W_DATA(w_data),
    .STAT_WR(stat_wr), .STAT_WDATA(stat_wdata), .ALU_OP(alu_op), .ALU_A(alu_a), .ALU_B(alu_b),
    .CLRWDT_EXEC(clrwdt), .SLEEP_EXEC(sleep), .WDT_TIMEOUT(wdt_to), .TIMER_EXT_CLOCK_PIN(pin),
    .STATUS_RD(status_rd), .ALU_RES(alu_res), .PC_PAGE(pc_page), .TIMER_CLOCK_SOURCE_SEL(cs),
    .TIMER_EDGE_SEL(se), .PRESCALER_ASSIGN(prescaler_assign), .PRESCALER_RATE(rate), .TMR_DIV_EXP(tdiv), .TMR_INC(tmr_inc));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one instruction plus an idle cycle, so back-to-back calls never retoggle a strobe in one step
  task automatic op(input logic c, input logic ld, input logic swr, input csr_op_t o,
                    input logic [7:0] a, input logic [7:0] b, input logic [7:0] w, input logic [7:0] s);
    ce = c; exec = 1'b1; opt_load = ld; stat_wr = swr; alu_op = o;
    alu_a = a; alu_b = b; w_data = w; stat_wdata = s;
    @(negedge clk);
    ce = 1'b1; exec = 1'b0; opt_load = 1'b0; stat_wr = 1'b0; alu_op = CSR_OP_NONE;
    @(negedge clk);
  endtask

  task automatic ev(input logic [2:0] e);
    {clrwdt, sleep, wdt_to} = e;
    @(negedge clk);
    {clrwdt, sleep, wdt_to} = 3'b000;
    @(negedge clk);
  endtask

  task automatic alu(input csr_op_t o, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] r, input logic [2:0] f);
    op(1'b1, 1'b0, 1'b0, o, a, b, 8'h00, 8'h00);
    chk(alu_res, r, "alu result");
    chk({5'h0, status_rd[2:0]}, {5'h0, f}, "alu flags");
  endtask

  // pin level held three cycles, noting any increment request
  task automatic pin_lvl(input logic lvl);
    pin = lvl;
    hit = 1'b0;
    repeat (3) begin
      @(negedge clk);
      hit = hit | tmr_inc;
    end
  endtask

  task automatic t_reset;
    chk(status_rd, 8'h18, "status after reset");
    chk({2'h0, cs, se, prescaler_assign, rate}, 8'h3f, "option after reset");
    chk({4'h0, tdiv}, 8'h08, "divide exponent after reset");
    chk({6'h0, pc_page}, 8'h00, "page after reset");
  endtask

  task automatic t_option;
    logic [2:0] r;
    for (int i = 0; i < 8; i++) begin
      r = i[2:0];
      op(1'b1, 1'b1, 1'b0, CSR_OP_NONE, 8'h00, 8'h00, {2'b11, ~r, r}, 8'h00);
      chk({2'h0, cs, se, prescaler_assign, rate}, {2'h0, ~r, r}, "option fields");
      chk({4'h0, tdiv}, {4'h0, 1'b0, r} + 8'h01, "divide exponent");
    end
    // clock enable low must not take the load
    op(1'b0, 1'b1, 1'b0, CSR_OP_NONE, 8'h00, 8'h00, 8'h00, 8'h00);
    chk({2'h0, cs, se, prescaler_assign, rate}, 8'h07, "option frozen");
  endtask

  task automatic t_timer;
    op(1'b1, 1'b1, 1'b0, CSR_OP_NONE, 8'h00, 8'h00, 8'hc0, 8'h00);
    pin_lvl(1'b0);
    chk({7'h0, tmr_inc}, 8'h01, "internal tick");
    op(1'b1, 1'b1, 1'b0, CSR_OP_NONE, 8'h00, 8'h00, 8'h20, 8'h00);
    pin_lvl(1'b0);
    pin_lvl(1'b1);
    chk({7'h0, hit}, 8'h01, "rising edge tick");
    pin_lvl(1'b0);
    chk({7'h0, hit}, 8'h00, "falling edge ignored");
    op(1'b1, 1'b1, 1'b0, CSR_OP_NONE, 8'h00, 8'h00, 8'h30, 8'h00);
    pin_lvl(1'b0);
    pin_lvl(1'b1);
    chk({7'h0, hit}, 8'h00, "rising edge ignored");
    pin_lvl(1'b0);
    chk({7'h0, hit}, 8'h01, "falling edge tick");
  endtask

  task automatic t_alu;
    alu(CSR_OP_ADD, 8'hf8, 8'h08, 8'h00, 3'b111);
    alu(CSR_OP_SUB, 8'h05, 8'h03, 8'h02, 3'b011);
    alu(CSR_OP_SUB, 8'h03, 8'h05, 8'hfe, 3'b000);
    alu(CSR_OP_LOGIC, 8'h00, 8'h00, 8'h00, 3'b100);
    alu(CSR_OP_RRF, 8'h01, 8'h00, 8'h00, 3'b101);
    alu(CSR_OP_RLF, 8'h00, 8'h00, 8'h01, 3'b100);
    alu(CSR_OP_RLF, 8'h80, 8'h00, 8'h00, 3'b101);
  endtask

  task automatic t_status;
    op(1'b1, 1'b0, 1'b1, CSR_OP_NONE, 8'h00, 8'h00, 8'h00, 8'he7);
    chk(status_rd, 8'hff, "status software write");
    chk({6'h0, pc_page}, 8'h03, "page to pc");
    // flag-updating op aimed at status keeps its own flags
    op(1'b1, 1'b0, 1'b1, CSR_OP_ADD, 8'h01, 8'h01, 8'h00, 8'h07);
    chk(status_rd, 8'h18, "flags kept over write");
    ev(3'b010);
    chk(status_rd, 8'h10, "after sleep");
    ev(3'b001);
    chk(status_rd, 8'h00, "after time-out");
    ev(3'b100);
    chk(status_rd, 8'h18, "after watchdog clear");
    ev(3'b101);
    chk(status_rd, 8'h08, "time-out beats clear");
  endtask

  // watchdog sized well above the expected run of under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_option();
    t_timer();
    t_alu();
    t_status();
    // second reset in mid-run restores every field
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
